/* File: verilog/four_mode_serial_port.sv */
// Function
// - Mode 00 is a synchronous shift register at core clock divided by twelve.
// - Mode 01 is 8-bit asynchronous at the variable rate.
// - Mode 10 is 9-bit asynchronous at a fixed core clock fraction.
// - Mode 11 is 9-bit asynchronous at the variable rate.
// - Variable rate generator uses an internal timer, 300 to 115200 baud.
// - Full duplex; received byte is buffered while the next byte arrives.
// - Buffer write loads transmitter; buffer read returns separate receive register.
// - Enhanced enable, together with the fraction timer bit, selects the serial timer; enhanced enable alone enables error detection.
// - Enhanced mode reports framing, break and overwrite errors in baud control.
// - 8-bit mode with multiprocessor bit: no receive-done without valid stop.
// - 9-bit modes with multiprocessor bit: no receive-done when ninth bit zero.
// - Reception happens only while the receive enable bit is one.
// - In 9-bit modes the transmit ninth bit is sent as ninth data bit.
// - Receive ninth-bit field latches ninth bit, or stop bit in 8-bit mode.
// - Transmit-done set after eighth shift bit or at stop start; software clears.
// - Receive-done set after eighth shift bit or mid stop bit; software clears.
// - Async modes: data enters on the receive line and leaves on the transmit line; mode 00 shifts both ways on the receive line.
// - Overwrite flag sets on a new character while receive-done; write 0 clears.
// - Read-only frame error flag updated per frame, set on a bad stop bit.
// - Break flag updated per frame, set when the line stays low too long.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module four_mode_serial_port #(
  parameter int STD_DIV = serial_port_pkg::STD_TICK_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out
);
  import serial_port_pkg::*;

  if (STD_DIV < 1 || STD_DIV > 65535) begin : g_div_check
    $error("STD_DIV out of range");
  end

  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  function automatic logic [15:0] tick_div(input logic [7:0] frac, input logic [2:0] div);
    // Fractional divider collapsed to an integer prescale of the timer
    tick_div = 16'((16'(frac[5:0]) + 16'd1) << div);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus slave
  control_t ctl_reg;
  logic [7:0] tx_data_reg;
  logic [7:0] rx_buf_reg;
  logic [7:0] frac_reg;
  logic [4:0] baud_cfg_reg;
  logic overwrite_reg, frame_err_reg, break_err_reg;
  logic enhanced_reg;
  logic wr_pend_reg;
  logic [9:0] wr_addr_reg;
  logic tx_start;
  logic set_tx_done, set_rx_done, set_overwrite, rx_frame_end, rx_frame_bad, rx_break;
  logic rx_ninth_val;
  logic [7:0] rx_byte_val;

  wire logic addr_phase = hsel && hready && htrans[1];
  wire logic [9:0] a_lo = haddr[9:0];
  // Full decode: registers must not alias at higher addresses
  wire logic hi_zero = haddr[31:10] == 22'h000000;
  wire logic wr_ctl = wr_pend_reg && wr_addr_reg == byte_addr(IDX_CONTROL);
  wire logic wr_buf = wr_pend_reg && wr_addr_reg == byte_addr(IDX_BUFFER);
  wire logic wr_frac = wr_pend_reg && wr_addr_reg == byte_addr(IDX_FRACTION);
  wire logic wr_bt = wr_pend_reg && wr_addr_reg == byte_addr(IDX_BAUD_TIMER);
  wire logic wr_cfg = wr_pend_reg && wr_addr_reg == byte_addr(IDX_CONFIG);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 10'h000;
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_reg <= addr_phase && hwrite && hi_zero;
      if (addr_phase) begin
        wr_addr_reg <= a_lo;
      end
      if (addr_phase && !hwrite) begin
        case (hi_zero ? a_lo : 10'h3FF)
          byte_addr(IDX_CONTROL): hrdata <= {24'h000000, ctl_reg};
          byte_addr(IDX_BUFFER): hrdata <= {24'h000000, rx_buf_reg};
          byte_addr(IDX_FRACTION): hrdata <= {24'h000000, frac_reg[7], 1'b0, frac_reg[5:0]};
          byte_addr(IDX_BAUD_TIMER): hrdata <= {24'h000000, overwrite_reg, frame_err_reg,
                                                break_err_reg, baud_cfg_reg};
          byte_addr(IDX_CONFIG): hrdata <= {31'h0000_0000, enhanced_reg};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Control register; hardware sets win over software clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_reg <= control_t'(CTL_RESET);
    end else if (clk_en) begin
      if (wr_ctl) begin
        ctl_reg <= control_t'(hwdata[7:0]);
      end
      if (set_tx_done) begin
        ctl_reg.tx_done <= 1'b1;
      end
      if (set_rx_done) begin
        ctl_reg.rx_done <= 1'b1;
        ctl_reg.rx_ninth <= rx_ninth_val;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frac_reg <= FD_RESET;
      baud_cfg_reg <= BT_CFG_RESET;
      enhanced_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      tx_start <= 1'b0;
    end else if (clk_en) begin
      if (wr_frac) begin
        frac_reg <= hwdata[7:0];
      end
      if (wr_bt) begin
        baud_cfg_reg <= hwdata[4:0];
      end
      if (wr_cfg) begin
        enhanced_reg <= hwdata[CFG_ENHANCED];
      end
      if (wr_buf) begin
        tx_data_reg <= hwdata[7:0];
      end
      // Start a cycle late so the new byte is already in the register
      tx_start <= wr_buf;
    end
  end

  // Enhanced error flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overwrite_reg <= 1'b0;
      frame_err_reg <= 1'b0;
      break_err_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_bt && !hwdata[BT_OVERWRITE]) begin
        overwrite_reg <= 1'b0;
      end
      if (enhanced_reg && set_overwrite) begin
        overwrite_reg <= 1'b1;
      end
      if (enhanced_reg && rx_frame_end) begin
        frame_err_reg <= rx_frame_bad;
        break_err_reg <= rx_break;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate generation: one tick at sixteen times the bit rate
  logic [15:0] tick_cnt_reg;
  logic [4:0] shift_cnt_reg;
  logic tick, shift_tick;
  wire logic use_timer = enhanced_reg && frac_reg[FD_TIMER_EN];
  wire logic [15:0] var_div = use_timer ? tick_div(frac_reg, baud_cfg_reg[BT_DIV_HI:BT_DIV_LO])
                                         : 16'(STD_DIV);
  wire logic [15:0] cur_div = (ctl_reg.mode == MODE_FIXED9) ? 16'(FIXED_DIV / OVERSAMPLE)
                                                            : var_div;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_reg <= 16'h0000;
      tick <= 1'b0;
      shift_cnt_reg <= 5'h00;
      shift_tick <= 1'b0;
    end else if (clk_en) begin
      tick <= tick_cnt_reg + 16'd1 >= cur_div;
      tick_cnt_reg <= (tick_cnt_reg + 16'd1 >= cur_div) ? 16'h0000 : tick_cnt_reg + 16'd1;
      // Half-period tick; two of them form one shift bit of twelve clocks
      shift_tick <= shift_cnt_reg == 5'(SHIFT_DIV / 2 - 1);
      shift_cnt_reg <= (shift_cnt_reg == 5'(SHIFT_DIV / 2 - 1)) ? 5'h00 : shift_cnt_reg + 5'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive line synchroniser
  logic rx_s1_reg, rx_s2_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else if (clk_en) begin
      rx_s1_reg <= rxd_in;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_ASYNC} tx_state_t;
  tx_state_t tx_state_reg;
  logic [10:0] tx_sh_reg;
  logic [3:0] tx_bits_reg, tx_sub_reg;
  logic sclk_phase_reg;
  wire logic nine = ctl_reg.mode[1];

  // Shift-mode receive capture, shared between tx engine and rx logic
  logic [7:0] sh_rx_reg;
  logic sh_rx_done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_reg <= TX_IDLE;
      tx_sh_reg <= 11'h7FF;
      tx_bits_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
      sclk_phase_reg <= 1'b0;
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
      set_tx_done <= 1'b0;
      sh_rx_done <= 1'b0;
      sh_rx_reg <= 8'h00;
    end else if (clk_en) begin
      set_tx_done <= 1'b0;
      sh_rx_done <= 1'b0;
      case (tx_state_reg)
        TX_IDLE: begin
          txd_out <= 1'b1;
          rxd_oe <= 1'b0;
          if (tx_start && ctl_reg.mode == MODE_SHIFT) begin
            tx_state_reg <= TX_SHIFT;
            tx_sh_reg <= {3'h7, tx_data_reg};
            tx_bits_reg <= 4'h0;
            sclk_phase_reg <= 1'b0;
          end else if (tx_start) begin
            tx_state_reg <= TX_ASYNC;
            tx_sh_reg <= {1'b1, nine ? ctl_reg.tx_ninth : 1'b1, tx_data_reg, 1'b0};
            tx_bits_reg <= 4'h0;
            tx_sub_reg <= 4'h0;
          end
        end
        TX_SHIFT: if (shift_tick) begin
          // Clock out on the transmit line, data both ways on receive line
          rxd_oe <= 1'b1;
          rxd_out <= tx_sh_reg[0];
          sclk_phase_reg <= !sclk_phase_reg;
          txd_out <= sclk_phase_reg;
          if (sclk_phase_reg) begin
            sh_rx_reg <= {rx_s2_reg, sh_rx_reg[7:1]};
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            tx_bits_reg <= tx_bits_reg + 4'd1;
            if (tx_bits_reg == 4'd7) begin
              tx_state_reg <= TX_IDLE;
              set_tx_done <= 1'b1;
              sh_rx_done <= ctl_reg.rx_en;
            end
          end
        end
        TX_ASYNC: if (tick) begin
          tx_sub_reg <= tx_sub_reg + 4'd1;
          if (tx_sub_reg == 4'd0) begin
            // Line changes only at bit boundaries, so each bit lasts sixteen ticks
            txd_out <= tx_sh_reg[0];
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            // Stop bit starts after start, eight data and optional ninth
            if (tx_bits_reg == (nine ? 4'd10 : 4'd9)) begin
              set_tx_done <= 1'b1;
            end
          end
          if (tx_sub_reg == 4'(OVERSAMPLE - 1)) begin
            tx_bits_reg <= tx_bits_reg + 4'd1;
            if (tx_bits_reg == (nine ? 4'd10 : 4'd9)) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Asynchronous receiver
  typedef enum logic [1:0] {RX_IDLE, RX_BITS} rx_state_t;
  rx_state_t rx_state_reg;
  logic [8:0] rx_sh_reg;
  logic [3:0] rx_bits_reg, rx_sub_reg;
  logic rx_all_low_reg;
  logic [7:0] rx_hold_reg;
  logic rx_hold_ninth_reg, rx_hold_stop_reg, rx_hold_low_reg;
  logic rx_async_done;
  logic rx_armed_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_reg <= RX_IDLE;
      rx_sh_reg <= 9'h000;
      rx_bits_reg <= 4'h0;
      rx_sub_reg <= 4'h0;
      rx_all_low_reg <= 1'b0;
      rx_async_done <= 1'b0;
      rx_hold_reg <= 8'h00;
      rx_hold_ninth_reg <= 1'b0;
      rx_hold_stop_reg <= 1'b0;
      rx_hold_low_reg <= 1'b0;
      rx_armed_reg <= 1'b0;
    end else if (clk_en) begin
      rx_async_done <= 1'b0;
      case (rx_state_reg)
        RX_IDLE: begin
          // Start needs a falling edge; a line left low by a break must not restart frames
          if (rx_s2_reg) begin
            rx_armed_reg <= 1'b1;
          end
          if (tick && rx_armed_reg && ctl_reg.rx_en && ctl_reg.mode != MODE_SHIFT && !rx_s2_reg) begin
            rx_state_reg <= RX_BITS;
            rx_armed_reg <= 1'b0;
            rx_bits_reg <= 4'h0;
            rx_sub_reg <= 4'h1;
            rx_all_low_reg <= 1'b1;
          end
        end
        RX_BITS: if (!ctl_reg.rx_en) begin
          rx_state_reg <= RX_IDLE;
        end else if (tick) begin
          rx_sub_reg <= rx_sub_reg + 4'd1;
          if (rx_s2_reg) begin
            rx_all_low_reg <= 1'b0;
          end
          if (rx_sub_reg == 4'(OVERSAMPLE / 2 - 1)) begin
            rx_bits_reg <= rx_bits_reg + 4'd1;
            if (rx_bits_reg == 4'd0 && rx_s2_reg) begin
              rx_state_reg <= RX_IDLE; // False start
            end else if (rx_bits_reg != 4'd0) begin
              rx_sh_reg <= {rx_s2_reg, rx_sh_reg[8:1]};
            end
            // Mid stop bit ends the frame
            if (rx_bits_reg == (nine ? 4'd10 : 4'd9)) begin
              rx_state_reg <= RX_IDLE;
              rx_async_done <= 1'b1;
              // Nine bits shifted in: data sits one place lower than in 8-bit frames
              rx_hold_reg <= nine ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
              rx_hold_ninth_reg <= nine ? rx_sh_reg[8] : rx_s2_reg;
              rx_hold_stop_reg <= rx_s2_reg;
              // Low through start, data, ninth and half stop
              rx_hold_low_reg <= rx_all_low_reg && !rx_s2_reg && rx_bits_reg >= 4'(BREAK_BITS - 2);
            end
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  always_comb begin
    rx_byte_val = sh_rx_done ? sh_rx_reg : rx_hold_reg;
    rx_ninth_val = rx_hold_ninth_reg;
    rx_frame_end = rx_async_done;
    rx_frame_bad = !rx_hold_stop_reg;
    rx_break = rx_hold_low_reg;
    set_rx_done = 1'b0;
    if (sh_rx_done) begin
      set_rx_done = 1'b1;
      rx_ninth_val = ctl_reg.rx_ninth;
    end else if (rx_async_done) begin
      if (!ctl_reg.multiproc) begin
        set_rx_done = 1'b1;
      end else if (nine) begin
        set_rx_done = rx_hold_ninth_reg;
      end else begin
        set_rx_done = rx_hold_stop_reg;
      end
    end
    set_overwrite = set_rx_done && ctl_reg.rx_done;
  end

  // Receive buffer is updated only when a byte is accepted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buf_reg <= 8'h00;
    end else if (clk_en) begin
      if (set_rx_done) begin
        rx_buf_reg <= rx_byte_val;
      end
    end
  end

  logic unused_ok;
  assign unused_ok = ^{htrans[0], hsize};

endmodule

`default_nettype wire

/* File: verilog/serial_port_pkg.sv */
package serial_port_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h98;
  localparam logic [7:0] IDX_BUFFER = 8'h99;
  localparam logic [7:0] IDX_FRACTION = 8'h9D;
  localparam logic [7:0] IDX_BAUD_TIMER = 8'h9E;
  localparam logic [7:0] IDX_CONFIG = 8'hAF;

  // Control register fields
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MULTIPROC = 5;
  localparam int CTL_RX_EN = 4;
  localparam int CTL_TX_NINTH = 3;
  localparam int CTL_RX_NINTH = 2;
  localparam int CTL_TX_DONE = 1;
  localparam int CTL_RX_DONE = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Baud timer control fields
  localparam int BT_OVERWRITE = 7;
  localparam int BT_FRAME = 6;
  localparam int BT_BREAK = 5;
  localparam int BT_DIV_HI = 2;
  localparam int BT_DIV_LO = 0;
  localparam logic [4:0] BT_CFG_RESET = 5'h00;

  // Fraction divider fields
  localparam int FD_TIMER_EN = 7;
  localparam logic [7:0] FD_RESET = 8'h00;

  // Config register: enhanced mode enable bit
  localparam int CFG_ENHANCED = 0;

  // Mode encodings
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] MODE_FIXED9 = 2'h2;
  localparam logic [1:0] MODE_VAR9 = 2'h3;

  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int SHIFT_DIV = 12;
  localparam int FIXED_DIV = 32;
  localparam int OVERSAMPLE = 16;
  localparam int BAUD_MIN = 300;
  localparam int BAUD_MAX = 115200;
  localparam int STD_BAUD = 9600;
  localparam int STD_TICK_DIV = CLK_HZ / (STD_BAUD * OVERSAMPLE);
  localparam int BREAK_BITS = 11;

  typedef struct packed {
    logic [1:0] mode;
    logic multiproc;
    logic rx_en;
    logic tx_ninth;
    logic rx_ninth;
    logic tx_done;
    logic rx_done;
  } control_t;

  typedef enum logic [1:0] {
    HTRANS_IDLE = 2'h0,
    HTRANS_BUSY = 2'h1,
    HTRANS_NONSEQ = 2'h2,
    HTRANS_SEQ = 2'h3
  } htrans_t;

endpackage

/* File: tb/serial_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_port_sva
  import serial_port_pkg::*;
#(
  parameter int STD_DIV = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rxd_oe,
  input wire logic txd_out
);
  localparam logic [31:0] A_CTL = {22'h0, IDX_CONTROL, 2'h0};
  localparam logic [31:0] A_CFG = {22'h0, IDX_CONFIG, 2'h0};
  localparam int STD_BIT = OVERSAMPLE * STD_DIV;
  logic take, ph_wr, ph_unm, enh_q, txd_last;
  logic [31:0] ph_addr;
  logic [1:0] mode_q;
  logic [15:0] run;
  assign take = hsel && hready && htrans[1] && clk_en;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_unm <= 1'b0;
      ph_addr <= 32'h0;
    end else if (clk_en && hready) begin
      ph_wr <= take && hwrite;
      ph_unm <= take && !hwrite && (haddr[31:12] != 20'h0);
      ph_addr <= haddr;
    end
  end
  // Mode is mirrored from bus writes, the checker has no register view
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= MODE_SHIFT;
      enh_q <= 1'b0;
    end else if (ph_wr && clk_en) begin
      if (ph_addr == A_CTL) mode_q <= hwdata[7:6];
      if (ph_addr == A_CFG) enh_q <= hwdata[CFG_ENHANCED];
    end
  end
  // Length of the txd run that ended one cycle ago; async bits last a full bit time, modes 01 and 11 checked only with enhanced mode off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_last <= 1'b1;
      run <= 16'hFFFF;
    end else begin
      txd_last <= txd_out;
      run <= (txd_out != txd_last) ? 16'h1 : ((run == 16'hFFFF) ? run : run + 16'h1);
    end
  end
  ////////////////////////////////////////////////////////////////
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready OKAY");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
  unmapped_zero_a: assert property (ph_unm |-> hrdata == 32'h0) else $error("unmapped read not zero");
  reset_idle_a: assert property ($rose(hresetn) |-> txd_out && !rxd_oe) else $error("lines not idle");
  oe_shift_a: assert property (rxd_oe |-> mode_q == MODE_SHIFT) else $error("rx line driven outside shift");
  async8_bit_a: assert property (txd_out != txd_last && mode_q == MODE_ASYNC8 && !enh_q |-> run >= STD_BIT)
    else $error("8-bit bit time short");
  fixed9_bit_a: assert property (txd_out != txd_last && mode_q == MODE_FIXED9 |-> run >= FIXED_DIV)
    else $error("fixed 9-bit bit time short");
  var9_bit_a: assert property (txd_out != txd_last && mode_q == MODE_VAR9 && !enh_q |-> run >= STD_BIT)
    else $error("variable 9-bit bit time short");
endmodule
bind four_mode_serial_port serial_port_sva #(.STD_DIV(STD_DIV)) i_sva (.hclk(hclk), .hresetn(hresetn),
  .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd_oe(rxd_oe), .txd_out(txd_out));
`default_nettype wire

/* File: tb/remote_station.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_station (
  input wire logic hclk,
  input wire logic txd,
  output logic rxd
);
  int bitlen = 16;
  logic [8:0] got;
  logic got_stop;
  // Idle line rests high between frames
  initial rxd = 1'b1;
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    @(posedge hclk);
    rxd <= 1'b0;
    repeat (bitlen) @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (bitlen) @(posedge hclk);
    end
    rxd <= stop;
    repeat (bitlen) @(posedge hclk);
    rxd <= 1'b1;
    repeat (2 * bitlen) @(posedge hclk);
  endtask
  task automatic hold_low(input int n);
    @(posedge hclk);
    rxd <= 1'b0;
    repeat (n) @(posedge hclk);
    rxd <= 1'b1;
    repeat (2 * bitlen) @(posedge hclk);
  endtask
  // Samples mid-bit so small start skew does not matter
  task automatic catch_frame(input int n);
    got = 9'h0;
    @(negedge txd);
    repeat (bitlen / 2) @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      repeat (bitlen) @(posedge hclk);
      got[i] = txd;
    end
    repeat (bitlen) @(posedge hclk);
    got_stop = txd;
  endtask
endmodule
`default_nettype wire

/* File: tb/four_mode_serial_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module four_mode_serial_port_bench;
  import serial_port_pkg::*;
  localparam int STD = 1;
  localparam int SB = OVERSAMPLE * STD;
  localparam logic [31:0] A_CTL = {22'h0, IDX_CONTROL, 2'h0};
  localparam logic [31:0] A_BUF = {22'h0, IDX_BUFFER, 2'h0};
  localparam logic [31:0] A_FD = {22'h0, IDX_FRACTION, 2'h0};
  localparam logic [31:0] A_BT = {22'h0, IDX_BAUD_TIMER, 2'h0};
  localparam logic [31:0] A_CFG = {22'h0, IDX_CONFIG, 2'h0};
  logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp, rxd_out, rxd_oe, txd_out, remote_rxd, rx_line;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int mismatches = 0;
  int n_checks = 0;
  int falls = 0;
  time t0, t1;
  logic oe_seen = 1'b0;
  logic [7:0] sh_got = 8'h00;
  four_mode_serial_port #(.STD_DIV(STD)) i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd_in(rx_line), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_out(txd_out));
  remote_station i_rem (.hclk(hclk), .txd(txd_out), .rxd(remote_rxd));
  // Shared data line: the port wins while it drives in shift mode
  assign rx_line = rxd_oe ? rxd_out : remote_rxd;
  always @(negedge txd_out) begin
    if (falls == 0) t0 = $time;
    t1 = $time;
    falls++;
  end
  always @(posedge hclk) if (rxd_oe === 1'b1) oe_seen = 1'b1;
  // Shift data stands unchanged across each rising shift clock
  always @(posedge txd_out) if (rxd_oe === 1'b1) sh_got = {rxd_out, sh_got[7:1]};
  ////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= HTRANS_IDLE;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, {24'h0, d}, r);
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chkr(input string s, input logic [31:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(s, {24'h0, e}, {24'h0, r[7:0] & m});
  endtask
  task automatic conclude();
    if (mismatches == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chkr("control reset", A_CTL, 8'hFF, CTL_RESET);
    chkr("fraction reset", A_FD, 8'hFF, FD_RESET);
    chkr("baud timer reset", A_BT, 8'hE0, 8'h00);
    chkr("unmapped read", 32'h1000, 8'hFF, 8'h00);
  endtask
  task automatic t_duplex();
    wr(A_CTL, 8'h50);
    fork
      i_rem.catch_frame(8);
      i_rem.send(9'h03C, 8, 1'b1);
      wr(A_BUF, 8'hA5);
    join
    chk("tx byte", 32'hA5, {24'h0, i_rem.got[7:0]});
    chk("tx stop", 32'h1, {31'h0, i_rem.got_stop});
    chkr("duplex flags", A_CTL, 8'hFF, 8'h57);
    chkr("rx buffer", A_BUF, 8'hFF, 8'h3C);
    wr(A_CTL, 8'h40);
    i_rem.send(9'h0C3, 8, 1'b1);
    chkr("rx disabled", A_CTL, 8'h01, 8'h00);
  endtask
  task automatic t_errors();
    wr(A_CTL, 8'h70);
    i_rem.send(9'h011, 8, 1'b0);
    chkr("mp bad stop", A_CTL, 8'h01, 8'h00);
    wr(A_CFG, 8'h01);
    i_rem.send(9'h011, 8, 1'b0);
    chkr("frame error", A_BT, 8'h40, 8'h40);
    wr(A_CTL, 8'h50);
    i_rem.send(9'h022, 8, 1'b1);
    chkr("stop latched", A_CTL, 8'h05, 8'h05);
    chkr("frame ok", A_BT, 8'hC0, 8'h00);
    i_rem.send(9'h033, 8, 1'b1);
    chkr("overwrite", A_BT, 8'h80, 8'h80);
    chkr("second byte", A_BUF, 8'hFF, 8'h33);
    wr(A_BT, 8'h00);
    chkr("overwrite clear", A_BT, 8'h80, 8'h00);
    wr(A_CTL, 8'h50);
    i_rem.hold_low(12 * SB);
    chkr("break", A_BT, 8'h20, 8'h20);
    wr(A_CFG, 8'h00);
  endtask
  task automatic t_nine();
    wr(A_CTL, 8'hF0);
    i_rem.send(9'h0AA, 9, 1'b1);
    chkr("ninth zero", A_CTL, 8'h01, 8'h00);
    i_rem.send(9'h1AA, 9, 1'b1);
    chkr("ninth one", A_CTL, 8'h05, 8'h05);
    chkr("9-bit data", A_BUF, 8'hFF, 8'hAA);
    wr(A_CTL, 8'hC0);
    fork
      i_rem.catch_frame(9);
      wr(A_BUF, 8'h3C);
    join
    chk("var9 ninth", 32'h03C, {23'h0, i_rem.got});
    repeat (SB) @(posedge hclk);
    wr(A_CTL, 8'h88);
    i_rem.bitlen = FIXED_DIV;
    fork
      i_rem.catch_frame(9);
      wr(A_BUF, 8'h96);
    join
    chk("ninth sent", 32'h196, {23'h0, i_rem.got});
    chkr("tx done", A_CTL, 8'h02, 8'h02);
  endtask
  task automatic t_timer();
    wr(A_CFG, 8'h01);
    wr(A_BT, 8'h01);
    wr(A_FD, 8'h81);
    wr(A_CTL, 8'h40);
    // Prescale (1+1)<<1 = 4 clocks per tick, sixteen ticks per bit
    i_rem.bitlen = OVERSAMPLE * 4;
    fork
      i_rem.catch_frame(8);
      wr(A_BUF, 8'h5A);
    join
    chk("timer rate", 32'h5A, {24'h0, i_rem.got[7:0]});
    wr(A_FD, 8'h00);
    wr(A_BT, 8'h00);
    wr(A_CFG, 8'h00);
  endtask
  task automatic t_shift();
    logic [31:0] r;
    wr(A_CTL, 8'h00);
    falls = 0;
    wr(A_BUF, 8'h5A);
    for (int k = 0; k < 400; k++) begin
      xfer(1'b0, A_CTL, 32'h0, r);
      if (r[CTL_TX_DONE] === 1'b1) break;
    end
    repeat (2 * SHIFT_DIV) @(posedge hclk);
    chk("shift done", 32'h1, {31'h0, r[CTL_TX_DONE]});
    chk("shift clocks", 32'h8, 32'(falls));
    chk("shift period", 32'(7 * SHIFT_DIV * 40), 32'(t1 - t0));
    chk("data drive", 32'h1, {31'h0, oe_seen});
    chk("shift data", 32'h5A, {24'h0, sh_got});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // Run needs about 3200 cycles; some eighteen times that signals a hang
  initial begin
    #(60000 * 40);
    mismatches++;
    conclude();
  end
  initial begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    i_rem.bitlen = SB;
    t_reset();
    t_duplex();
    t_errors();
    t_nine();
    t_timer();
    t_shift();
    conclude();
  end
endmodule
`default_nettype wire
